// ### mcu_host_model.sv
// host controller model: one strobed request per call
// assumes calls start just after a rising edge
`timescale 1ns/10ps
module mcu_host_model (
  input wire logic core_clk,
  output memsel_pkg::host_bus_t host
);
  initial host = '0;
  // a[20] is wide mode, a[19:16] the high address nibble
  // an edge passes first, so back-to-back calls never move the lines twice in one step
  task automatic cyc(input logic [20:0] a, input logic [2:0] s, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    host = '{a[15:0], a[19:16], a[20], s[2], s[1], s[0], d};
    @(posedge core_clk);
    #1;
    // released with inverted address and data and all other lines low, never a stale copy
    host = '{~a[15:0], 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, ~d};
  endtask
endmodule // mcu_host_model

// ### memory_select_decoder.sv
// memory select decoder: address decode, space map, page register, power modes
// assumes host strobes synchronous to core_clk and decode equations given as
// per-target address match/mask pairs loaded from configuration inputs
// Overview of operation
// - flash lock status: bit i set means flash sector i is write protected
// - eeprom lock status bits 3..0 mark eeprom sectors 0..3 protected
// - eeprom status bit 7 shows the readout lock flag
// - sram enabled only while sram_select is high
// - sram_select is the or of at most two product terms
// - eeprom select overrides an overlapping flash select
// - sram, config or periph select overrides any memory sector
// - three priority levels; higher level wins over lower
// - space map gates program strobes per memory and flash/eeprom read strobes, bit 7 periph mode
// - space map has a reset value, takes space_map_init on the first edge after reset, then is rewritable
// - page register, eight bits, read and write at window offset E0
// - page bits 3..0 feed the select terms, all eight leave the block
// - speed bit off puts arrays in standby after 70 ns of idle inputs
// - power reg two bits block host control signals into the arrays
// - arrays see a 73-signal input bus
// - wide mode feeds address bits 19..4 instead of 15..0
// - 8 flash, 4 eeprom, sram, config, jtag and 2 periph selects
// - lock bits read only from the host
// - program or erase to a locked sector is dropped
`timescale 1ns/10ps
`include "memsel_map.svh"
module memory_select_decoder (
  input wire logic core_clk,
  input wire logic rst,
  input memsel_pkg::host_bus_t host,
  input wire logic [7:0] flash_lock,
  input wire logic [3:0] eeprom_lock,
  input wire logic readout_lock,
  input wire logic [19:0] term_match [19],
  input wire logic [19:0] term_mask [19],
  input wire logic [7:0] space_map_init,
  input wire logic [43:0] array_other_inputs,
  input wire logic program_request,
  output memsel_pkg::select_t sel,
  output logic sram_enable,
  output logic program_allowed,
  output logic [7:0] rdata,
  output logic rdata_oe,
  output logic [7:0] page_bits,
  output logic [72:0] array_inputs,
  output logic arrays_standby
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] space_map;
    logic [7:0] page;
    logic [7:0] pm_zero;
    logic [7:0] pm_two;
    logic [72:0] last_inputs;
    logic [7:0] idle_cnt;
    memsel_pkg::power_state_t pwr;
    memsel_pkg::select_t sel;
    logic [7:0] rdata;
    logic rdata_oe;
    logic map_loaded;
  } state_t;
  state_t cur, next_cur;
  // one product term: all unmasked address bits equal the match word
  function automatic logic term_hit(input logic [19:0] a, input logic [19:0] m,
                                    input logic [19:0] k);
    term_hit = ((a ^ m) & k) == 20'h00000;
  endfunction
  // address seen by the arrays; page bits 3..0 form the top nibble of the decode address
  logic [15:0] arr_addr;
  logic [19:0] full_addr;
  logic [18:0] raw_hit;
  logic [2:0] ctrl_in;
  logic cfg_access;
  always_comb begin
    arr_addr = host.wide_mode ? {host.addr_hi, host.addr[15:4]} : host.addr;
    full_addr = {cur.page[3:0], arr_addr};
  end
  // terms 0..7 flash, 8..11 eeprom, 12..13 sram, 14 cfg, 15 jtag, 16..17 periph
  genvar gi;
  generate
    for (gi = 0; gi < 19; gi++) begin : g_term
      assign raw_hit[gi] = term_hit(full_addr, term_match[gi], term_mask[gi]);
    end
  endgenerate
  // ****************************************
  // next state
  // ****************************************
  logic any_strobe, prog_ok_sram, prog_ok_ee, prog_ok_fl, lvl1;
  logic [72:0] bus_now;
  always_comb begin
    next_cur = cur;
    any_strobe = host.prog_strobe | host.read_strobe | host.write_strobe;
    // space map gates per strobe type
    prog_ok_sram = host.prog_strobe & cur.space_map[`SM_SRAM_CODE];
    prog_ok_ee = (host.prog_strobe & cur.space_map[`SM_EEPROM_IN_PROGRAM_SPACE]) |
                 (host.read_strobe & cur.space_map[`SM_EEPROM_IN_DATA_SPACE]) | host.write_strobe;
    prog_ok_fl = (host.prog_strobe & cur.space_map[`SM_FLASH_IN_PROGRAM_SPACE]) |
                 (host.read_strobe & cur.space_map[`SM_FLASH_IN_DATA_SPACE]) | host.write_strobe;
    // level one: sram, config and periph space
    next_cur.sel.sram = (raw_hit[12] | raw_hit[13]) & any_strobe &
                        (~host.prog_strobe | prog_ok_sram);
    next_cur.sel.cfg = raw_hit[14] & (host.read_strobe | host.write_strobe);
    next_cur.sel.periph = raw_hit[17:16] & {2{cur.space_map[`SM_PERIPH_IO_MODE_ENABLE]}} &
                          {2{host.read_strobe | host.write_strobe}};
    next_cur.sel.jtag = raw_hit[15];
    lvl1 = next_cur.sel.sram | next_cur.sel.cfg | (|next_cur.sel.periph);
    // level two eeprom over level three flash
    next_cur.sel.eeprom = lvl1 ? 4'h0 : (raw_hit[11:8] & {4{prog_ok_ee}});
    next_cur.sel.flash = (lvl1 | (|next_cur.sel.eeprom)) ? 8'h00 :
                         (raw_hit[7:0] & {8{prog_ok_fl}});
    // register writes in the config window
    cfg_access = raw_hit[14];
    if (cfg_access & host.write_strobe) begin
      case (host.addr[7:0])
        `OFS_SPACE_MAP: next_cur.space_map = host.wdata;
        `OFS_PAGE: next_cur.page = host.wdata;
        `OFS_POWER_ZERO: next_cur.pm_zero = host.wdata;
        `OFS_POWER_TWO: next_cur.pm_two = host.wdata;
        default: ; // lock status offsets ignore writes
      endcase
    end
    // load configured initial value once after reset
    if (!cur.map_loaded) begin
      next_cur.space_map = space_map_init;
      next_cur.map_loaded = 1'b1;
    end
    // register reads; no match leaves the bus undriven
    next_cur.rdata_oe = 1'b0;
    next_cur.rdata = 8'h00;
    if (cfg_access & host.read_strobe) begin
      next_cur.rdata_oe = 1'b1;
      case (host.addr[7:0])
        `OFS_FLASH_LOCK: next_cur.rdata = flash_lock;
        `OFS_EEPROM_LOCK: next_cur.rdata = {readout_lock, 3'h0, eeprom_lock};
        `OFS_SPACE_MAP: next_cur.rdata = cur.space_map;
        `OFS_PAGE: next_cur.rdata = cur.page;
        `OFS_POWER_ZERO: next_cur.rdata = cur.pm_zero;
        `OFS_POWER_TWO: next_cur.rdata = cur.pm_two;
        default: next_cur.rdata_oe = 1'b0;
      endcase
    end
    // control lines masked by power reg two before the arrays
    ctrl_in = {host.write_strobe & ~cur.pm_two[2], host.read_strobe & ~cur.pm_two[1],
               host.prog_strobe & ~cur.pm_two[0]};
    // ports, port d, feedbacks and ready/busy arrive as one 44-bit group
    bus_now = {arr_addr, ctrl_in, rst, 1'b0, cur.page, array_other_inputs};
    // idle detect for standby when speed bit is off
    if (bus_now != cur.last_inputs) begin
      next_cur.idle_cnt = 8'h00;
      next_cur.pwr = memsel_pkg::ACTIVE;
    end else begin
      case (cur.pwr)
        memsel_pkg::ACTIVE: begin
          if (cur.idle_cnt >= 8'(`IDLE_CYCLES - 1) && !cur.pm_zero[`PM0_SPEED])
            next_cur.pwr = memsel_pkg::STANDBY;
          else if (cur.idle_cnt != 8'hFF)
            next_cur.idle_cnt = cur.idle_cnt + 8'h01;
        end
        memsel_pkg::STANDBY: begin
          if (cur.pm_zero[`PM0_SPEED])
            next_cur.pwr = memsel_pkg::ACTIVE;
        end
        default: next_cur.pwr = memsel_pkg::ACTIVE;
      endcase
    end
    next_cur.last_inputs = bus_now;
  end
  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.space_map <= `SPACE_MAP_RESET;
      cur.page <= `PAGE_RESET;
      cur.pm_zero <= `PM_RESET;
      cur.pm_two <= `PM_RESET;
      cur.pwr <= memsel_pkg::ACTIVE;
    end else begin
      cur <= next_cur;
    end
  end
  // outputs
  logic [11:0] locks_of_sel;
  always_comb begin
    sel = cur.sel;
    sram_enable = cur.sel.sram;
    locks_of_sel = {flash_lock & cur.sel.flash, eeprom_lock & cur.sel.eeprom};
    program_allowed = program_request & ~(|locks_of_sel);
    rdata = cur.rdata;
    rdata_oe = cur.rdata_oe;
    page_bits = cur.page;
    array_inputs = cur.last_inputs;
    arrays_standby = cur.pwr == memsel_pkg::STANDBY;
  end
endmodule // memory_select_decoder

// ### memory_select_decoder_properties.sv
// checker for the memory select decoder outputs
// assumes bind by name onto the decoder, one clock domain
`timescale 1ns/10ps
module memory_select_decoder_properties (
  input wire logic core_clk,
  input wire logic rst,
  input memsel_pkg::host_bus_t host,
  input wire logic [7:0] flash_lock,
  input wire logic [3:0] eeprom_lock,
  input wire logic readout_lock,
  input wire logic program_request,
  input memsel_pkg::select_t sel,
  input wire logic sram_enable,
  input wire logic program_allowed,
  input wire logic [7:0] rdata,
  input wire logic rdata_oe,
  input wire logic [7:0] page_bits
);
  // ********
  // selects and window registers
  // ********
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // the ram is only ever enabled by a strobe seen one edge back
  property p_sram; sram_enable |-> $past(host.prog_strobe | host.read_strobe |
    host.write_strobe); endproperty
  a_sram: assert property (p_sram) else $error("sram enable");
  property p_ee; |sel.eeprom |-> sel.flash == 8'h00; endproperty
  a_ee: assert property (p_ee) else $error("flash beside eeprom");
  property p_lvl; sel.sram || sel.cfg || |sel.periph |-> {sel.flash, sel.eeprom} == 12'h0;
  endproperty
  a_lvl: assert property (p_lvl) else $error("sector beside level one");
  // a cfg hit means the request one edge back sat in the window
  property p_page; sel.cfg && $past(host.write_strobe) && $past(host.addr[7:0]) == 8'hE0
    |-> page_bits == $past(host.wdata); endproperty
  a_page: assert property (p_page) else $error("page write");
  property p_flk; sel.cfg && $past(host.read_strobe) && $past(host.addr[7:0]) == 8'hC0
    |-> rdata_oe && rdata == $past(flash_lock); endproperty
  a_flk: assert property (p_flk) else $error("flash lock read");
  property p_elk; sel.cfg && $past(host.read_strobe) && $past(host.addr[7:0]) == 8'hC2
    |-> rdata == {$past(readout_lock), 3'h0, $past(eeprom_lock)}; endproperty
  a_elk: assert property (p_elk) else $error("eeprom lock read");
  property p_idle; sel == '0 |-> !rdata_oe; endproperty
  a_idle: assert property (p_idle) else $error("bus driven unmapped");
  property p_prog; !program_request || |(sel.flash & flash_lock) ||
    |(sel.eeprom & eeprom_lock) |-> !program_allowed; endproperty
  a_prog: assert property (p_prog) else $error("program on lock");
  c_sram: cover property (sel.sram);
  c_page: cover property (sel.cfg && page_bits != 8'h00);
  c_prog: cover property (program_allowed);
endmodule // memory_select_decoder_properties
bind memory_select_decoder memory_select_decoder_properties i_props (.*);

// ### memsel_map.svh
// offsets, field positions and reset values for the memory select decoder
// assumes inclusion from the decoder module and the bench only
`ifndef MEMSEL_MAP_SVH
`define MEMSEL_MAP_SVH
// ****************************************
// register offsets inside the config window
// ****************************************
`define OFS_FLASH_LOCK 8'hC0
`define OFS_EEPROM_LOCK 8'hC2
`define OFS_SPACE_MAP 8'hC4
`define OFS_PAGE 8'hE0
`define OFS_POWER_ZERO 8'hB0
`define OFS_POWER_TWO 8'hB4
// ****************************************
// field positions
// ****************************************
`define SM_SRAM_CODE 0
`define SM_EEPROM_IN_PROGRAM_SPACE 1
`define SM_FLASH_IN_PROGRAM_SPACE 2
`define SM_EEPROM_IN_DATA_SPACE 3
`define SM_FLASH_IN_DATA_SPACE 4
`define SM_PERIPH_IO_MODE_ENABLE 7
`define PM0_SPEED 2
`define EE_READOUT_LOCK 7
// ****************************************
// reset values and timing
// ****************************************
`define SPACE_MAP_RESET 8'h0C
`define PAGE_RESET 8'h00
`define PM_RESET 8'h00
`define IDLE_TIME_NS 70
`define CLK_PERIOD_NS 4
`define IDLE_CYCLES ((`IDLE_TIME_NS) / (`CLK_PERIOD_NS))
`endif

// ### memsel_pkg.sv
// types shared by the memory select decoder
// assumes the map header holds every number
package memsel_pkg;
  // host bus request, sampled on core_clk
  typedef struct packed {
    logic [15:0] addr;
    logic [3:0] addr_hi;
    logic wide_mode;
    logic prog_strobe;
    logic read_strobe;
    logic write_strobe;
    logic [7:0] wdata;
  } host_bus_t;
  // decoded selects after priority
  typedef struct packed {
    logic [7:0] flash;
    logic [3:0] eeprom;
    logic sram;
    logic cfg;
    logic jtag;
    logic [1:0] periph;
  } select_t;
  typedef enum logic [0:0] {ACTIVE, STANDBY} power_state_t;
endpackage

// ### test_memory_select_decoder.sv
// bench for the memory select decoder, host model on its bus
// assumes a 4 ns core clock and the window offsets of the map header
`timescale 1ns/10ps
`include "memsel_map.svh"
module test_memory_select_decoder;
  logic core_clk, rst, readout_lock, program_request, sram_enable, program_allowed;
  logic rdata_oe, arrays_standby;
  logic [7:0] flash_lock, rdata, page_bits;
  logic [3:0] eeprom_lock;
  logic [72:0] array_inputs;
  logic [19:0] term_match [19];
  logic [19:0] term_mask [19];
  memsel_pkg::host_bus_t host;
  memsel_pkg::select_t sel;
  int n_errors = 0;
  int tests_run = 0;
  mcu_host_model i_host (.*);
  memory_select_decoder i_dut (.*, .space_map_init(8'h1C), .array_other_inputs(44'h0));
  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  // the answer stands only from the sampling edge to the next, so look at once
  task automatic rd(input logic [20:0] a, input logic [2:0] s = 3'b010);
    i_host.cyc(a, s, 8'h00);
  endtask
  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_map;
    rd({8'hF0, `OFS_SPACE_MAP});
    chk(rdata, 8'h1C);
    rd(16'h8800);
    chk(sel, 17'h200);
    i_host.cyc({8'hF0, `OFS_SPACE_MAP}, 3'b001, 8'h0C);
    rd(16'h8800);
    chk(sel, 17'h0);
    rd(16'h8800, 3'b100);
    chk(sel, 17'h200);
    rd(16'h5000);
    chk(sel, 17'h0);
    i_host.cyc({8'hF0, `OFS_SPACE_MAP}, 3'b001, 8'h9C);
    rd(16'h5000);
    chk(sel, 17'h1);
    rd(16'h8800);
    chk(sel, 17'h200);
  endtask
  task automatic t_prio;
    rd(16'h8000);
    chk({sel, sram_enable}, 18'h21);
    rd(16'h4000);
    chk(sel, 17'h10);
    rd(16'h8400);
    chk(sel, 17'h20);
    rd(16'h7000);
    chk({sel, rdata_oe}, 18'h0);
    // wide mode: high nibble 8 and bits 15..4 of 8000 land on flash 0, not the ram
    rd(21'h188000);
    chk(sel, 17'h200);
  endtask
  // read straight after write, then a page that moves flash 0 to sector 7
  task automatic t_page;
    i_host.cyc({8'hF0, `OFS_PAGE}, 3'b001, 8'hA1);
    rd({8'hF0, `OFS_PAGE});
    chk({page_bits, rdata, rdata_oe}, 17'h14343);
    rd(16'h8800);
    chk(sel, 17'h10000);
    i_host.cyc({8'hF0, `OFS_PAGE}, 3'b001, 8'h00);
  endtask
  task automatic t_lock;
    i_host.cyc({8'hF0, `OFS_FLASH_LOCK}, 3'b001, 8'h00);
    rd({8'hF0, `OFS_FLASH_LOCK});
    chk({rdata_oe, rdata}, 9'h1A5);
    rd({8'hF0, `OFS_EEPROM_LOCK});
    chk(rdata, 8'h89);
    program_request = 1'b1;
    rd(16'h8800, 3'b100);
    chk(program_allowed, 1'b0);
    rd(16'h9000, 3'b100);
    chk(program_allowed, 1'b1);
    program_request = 1'b0;
  endtask
  task automatic t_idle;
    int i;
    for (i = 0; i < 40 && arrays_standby !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    // a used-up bound leaves i at 40 and fails here
    chk(i >= `IDLE_CYCLES && i <= `IDLE_CYCLES + 2, 1'b1);
    // released address of the last request leads the array bus, strobes low
    chk(array_inputs[72:54], {16'h6FFF, 3'h0});
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // eeprom 0 and sram overlap flash 0; flash 7 needs page 1
  initial begin
    rst = 1'b1;
    flash_lock = 8'hA5;
    eeprom_lock = 4'h9;
    readout_lock = 1'b1;
    program_request = 1'b0;
    term_match = '{20'h08000, 20'h09000, 20'h0A000, 20'h0B000, 20'h0C000, 20'h0D000,
      20'h0E000, 20'h18000, 20'h08000, 20'h01000, 20'h02000, 20'h03000, 20'h08000,
      20'h04000, 20'h0F000, 20'h0F100, 20'h05000, 20'h05100, 20'hFFFFF};
    term_mask = '{20'hFF000, 20'hFF000, 20'hFF000, 20'hFF000, 20'hFF000, 20'hFF000,
      20'hFF000, 20'hFF000, 20'hFF800, 20'hFF000, 20'hFF000, 20'hFF000, 20'hFFC00,
      20'hFF000, 20'h0FF00, 20'h0FF00, 20'hFFF00, 20'hFFF00, 20'hFFFFF};
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    @(posedge core_clk);
    #1;
    t_map();
    t_prio();
    t_page();
    t_lock();
    t_idle();
    stop_test();
  end
endmodule // test_memory_select_decoder
